// ### hdl/prcd_decoder.sv
// power-up clock ratio decoder with ahb-lite status/control registers
// How it works
// - cluster ratios come from the word captured once at power-up only
// - cluster code 8..18 gives multiplier 8..18; others reserved
// - complexes 0,1: 0000 pll one /1, 0001 pll one /2, 0100 pll two /1
// - complexes 2,3: 0000 pll one /1, 0100 pll two /1, 0101 pll two /2
// - async memory ratio codes 5,6,8,9,10,12,13,16,18 valid; others reserved
// - sync memory: platform reference, only ratio 1 valid, range 01 above 600 MHz
// - serdes bank1 010/011/100 give 25/40/50; bank2 adds 20,24,30
// - bank1 divider: five bits, one per lane pair, set halves rate
// - one bank2 divider bit covers all four lanes, set halves rate
// - memory pll reference: system clock async, platform clock sync
`timescale 1ns/1ps
`include "prcd_consts.svh"
module prcd_decoder
  import prcd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cfg_valid,
  input wire logic [4:0] cluster_pll_multiplier_one,
  input wire logic [4:0] cluster_pll_multiplier_two,
  input wire logic [1:0] cluster_pll_range_one,
  input wire logic [1:0] cluster_pll_range_two,
  input wire logic [15:0] core_complex_clock_select,
  input wire logic [4:0] memory_pll_multiplier,
  input wire logic [1:0] memory_pll_range,
  input wire logic memory_sync_mode,
  input wire logic memory_rate_bit,
  input wire logic memory_reserved_bit,
  input wire logic [2:0] serdes_bank1_multiplier,
  input wire logic [2:0] serdes_bank2_multiplier,
  input wire logic [4:0] serdes_bank1_lane_divider,
  input wire logic serdes_bank2_lane_divider,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic cfg_locked,
  output logic cfg_error,
  output logic [4:0] cluster_one_mult_r,
  output logic [4:0] cluster_two_mult_r,
  output logic [1:0] cluster_one_range_r,
  output logic [1:0] cluster_two_range_r,
  output logic [3:0] core_src_pll_two_r,
  output logic [3:0] core_div2_r,
  output logic [4:0] mem_mult_r,
  output logic [1:0] mem_range_r,
  output logic mem_ref_platform_r,
  output logic [5:0] serdes_bank1_mult_r,
  output logic [5:0] serdes_bank2_mult_r,
  output logic [4:0] serdes_bank1_div2_r,
  output logic [3:0] serdes_bank2_div2_r
);
  logic [`PRCD_CFG_W-1:0] cfg_in;
  logic [`PRCD_CFG_W-1:0] cfg;
  logic locked;
  logic force_safe_r;
  logic [12:0] err;
  logic [12:0] err_r;
  logic [7:0] addr_r;
  logic wr_pend_r;
  logic [31:0] rd_nxt;
  logic [31:0] hrdata_r;
  logic acc;

  // field unpacking of the captured word
  logic [4:0] c_cl1, c_cl2, c_mem;
  logic [1:0] c_rg1, c_rg2, c_mrg;
  logic [15:0] c_sel;
  logic c_sync, c_rate, c_rsv, c_bd2;
  logic [2:0] c_sd1, c_sd2;
  logic [4:0] c_bd1;

  assign cfg_in = {cluster_pll_multiplier_one, cluster_pll_multiplier_two, cluster_pll_range_one,
                   cluster_pll_range_two, core_complex_clock_select, memory_pll_multiplier,
                   memory_pll_range, memory_sync_mode, memory_rate_bit, memory_reserved_bit,
                   serdes_bank1_multiplier, serdes_bank2_multiplier, serdes_bank1_lane_divider,
                   serdes_bank2_lane_divider};
  assign {c_cl1, c_cl2, c_rg1, c_rg2, c_sel, c_mem, c_mrg, c_sync, c_rate, c_rsv,
          c_sd1, c_sd2, c_bd1, c_bd2} = cfg;

  prcd_cfg_capture u_cap (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg_valid(cfg_valid),
    .cfg_in(cfg_in),
    .cfg_r(cfg),
    .locked(locked)
  );

  // {error, multiplier}
  function automatic logic [5:0] cl_dec(input logic [4:0] code);
    if (code >= `PRCD_CL_MULT_MIN && code <= `PRCD_CL_MULT_MAX) begin
      cl_dec = {1'b0, code};
    end else begin
      cl_dec = {1'b1, `PRCD_CL_SAFE};
    end
  endfunction

  // {error, source pll two, divide by 2}; upper selects the complex 2,3 table
  function automatic logic [2:0] sel_dec(input logic [3:0] code, input logic upper);
    sel_dec = upper ? {1'b1, PRCD_SRC_PLL_TWO, 1'b1} : {1'b1, PRCD_SRC_PLL_ONE, 1'b1};
    if (code == `PRCD_SEL_P1_D1) sel_dec = {1'b0, PRCD_SRC_PLL_ONE, 1'b0};
    if (code == `PRCD_SEL_P2_D1) sel_dec = {1'b0, PRCD_SRC_PLL_TWO, 1'b0};
    if (!upper && code == `PRCD_SEL_P1_D2) sel_dec = {1'b0, PRCD_SRC_PLL_ONE, 1'b1};
    if (upper && code == `PRCD_SEL_P2_D2) sel_dec = {1'b0, PRCD_SRC_PLL_TWO, 1'b1};
  endfunction

  // {error, multiplier}; bank2 accepts the wider set
  function automatic logic [6:0] sd_dec(input logic [2:0] code, input logic bank2);
    sd_dec = {1'b1, `PRCD_SD_SAFE};
    if (code == `PRCD_SD_C25) sd_dec = {1'b0, `PRCD_SD_M25};
    if (code == `PRCD_SD_C40) sd_dec = {1'b0, `PRCD_SD_M40};
    if (code == `PRCD_SD_C50) sd_dec = {1'b0, `PRCD_SD_M50};
    if (bank2 && code == `PRCD_SD_C20) sd_dec = {1'b0, `PRCD_SD_M20};
    if (bank2 && code == `PRCD_SD_C24) sd_dec = {1'b0, `PRCD_SD_M24};
    if (bank2 && code == `PRCD_SD_C30) sd_dec = {1'b0, `PRCD_SD_M30};
  endfunction

  logic [5:0] cl1_d, cl2_d;
  logic [2:0] sel_d [4];
  logic [6:0] sd1_d, sd2_d;
  logic mem_ok;

  assign cl1_d = cl_dec(c_cl1);
  assign cl2_d = cl_dec(c_cl2);
  assign sd1_d = sd_dec(c_sd1, 1'b0);
  assign sd2_d = sd_dec(c_sd2, 1'b1);
  assign sel_d[0] = sel_dec(c_sel[15:12], 1'b0);
  assign sel_d[1] = sel_dec(c_sel[11:8], 1'b0);
  assign sel_d[2] = sel_dec(c_sel[7:4], 1'b1);
  assign sel_d[3] = sel_dec(c_sel[3:0], 1'b1);

  always_comb begin
    if (c_sync) begin
      mem_ok = (c_mem == `PRCD_MEM_SYNC_RATIO);
    end else begin
      unique case (c_mem)
        `PRCD_MEM_R5, `PRCD_MEM_R6, `PRCD_MEM_R8, `PRCD_MEM_R9, `PRCD_MEM_R10,
        `PRCD_MEM_R12, `PRCD_MEM_R13, `PRCD_MEM_R16, `PRCD_MEM_R18: mem_ok = 1'b1;
        default: mem_ok = 1'b0;
      endcase
    end
  end

  // a mode-bit violation by the loader is reported, not corrected
  assign err[11:0] = {c_rsv, (!c_sync && c_rate), sd2_d[6], sd1_d[6], !mem_ok,
                      sel_d[3][2], sel_d[2][2], sel_d[1][2], sel_d[0][2], cl2_d[5], cl1_d[5], locked};
  assign err[12] = |err[11:1];

  // errors only mean something once a word is held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      err_r <= '0;
    end else begin
      err_r <= locked ? err : 13'h0000;
    end
  end

  // cluster and core outputs; safe until a word is locked or when forced
  always_ff @(posedge sys_clk) begin
    if (rst || !locked || force_safe_r) begin
      cluster_one_mult_r <= `PRCD_CL_SAFE;
      cluster_two_mult_r <= `PRCD_CL_SAFE;
      cluster_one_range_r <= '0;
      cluster_two_range_r <= '0;
      core_src_pll_two_r <= `PRCD_CORE_SRC_SAFE;
      core_div2_r <= `PRCD_CORE_DIV_SAFE;
    end else begin
      cluster_one_mult_r <= cl1_d[4:0];
      cluster_two_mult_r <= cl2_d[4:0];
      cluster_one_range_r <= c_rg1;
      cluster_two_range_r <= c_rg2;
      for (int i = 0; i < 4; i++) begin
        core_src_pll_two_r[i] <= sel_d[i][1];
        core_div2_r[i] <= sel_d[i][0];
      end
    end
  end

  // memory pll
  always_ff @(posedge sys_clk) begin
    if (rst || !locked || force_safe_r) begin
      mem_mult_r <= `PRCD_MEM_ASYNC_SAFE;
      mem_range_r <= '0;
      mem_ref_platform_r <= 1'b0;
    end else begin
      mem_ref_platform_r <= c_sync;
      mem_range_r <= c_mrg;
      if (mem_ok) begin
        mem_mult_r <= c_mem;
      end else begin
        mem_mult_r <= c_sync ? `PRCD_MEM_SYNC_RATIO : `PRCD_MEM_ASYNC_SAFE;
      end
    end
  end

  // serdes multipliers and lane dividers
  always_ff @(posedge sys_clk) begin
    if (rst || !locked || force_safe_r) begin
      serdes_bank1_mult_r <= `PRCD_SD_SAFE;
      serdes_bank2_mult_r <= `PRCD_SD_SAFE;
      serdes_bank1_div2_r <= `PRCD_SD_B1_DIV_SAFE;
      serdes_bank2_div2_r <= `PRCD_SD_B2_DIV_SAFE;
    end else begin
      serdes_bank1_mult_r <= sd1_d[5:0];
      serdes_bank2_mult_r <= sd2_d[5:0];
      serdes_bank1_div2_r <= c_bd1;
      serdes_bank2_div2_r <= {4{c_bd2}};
    end
  end

  assign cfg_locked = locked;
  assign cfg_error = err_r[12];

  // ahb-lite slave, zero wait states, always okay
  assign acc = hsel && hready && (htrans == `PRCD_HTRANS_NONSEQ || htrans == `PRCD_HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_comb begin
    unique case (haddr[7:0])
      `PRCD_REG_STATUS: rd_nxt = {19'h00000, err_r};
      `PRCD_REG_CLUSTER: rd_nxt = {12'h000, cluster_two_range_r, cluster_one_range_r,
                                   3'h0, cluster_two_mult_r, 3'h0, cluster_one_mult_r};
      `PRCD_REG_CORE: rd_nxt = {24'h000000, core_div2_r, core_src_pll_two_r};
      `PRCD_REG_MEM: rd_nxt = {24'h000000, mem_ref_platform_r, mem_range_r, mem_mult_r};
      `PRCD_REG_SERDES: rd_nxt = {7'h00, serdes_bank2_div2_r, serdes_bank1_div2_r,
                                  2'h0, serdes_bank2_mult_r, 2'h0, serdes_bank1_mult_r};
      `PRCD_REG_CONTROL: rd_nxt = {31'h00000000, force_safe_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // read data sampled at the address phase, so it stands through the data phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata_r <= '0;
    end else if (acc && !hwrite) begin
      hrdata_r <= rd_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      addr_r <= '0;
    end else begin
      wr_pend_r <= acc && hwrite;
      if (acc) addr_r <= haddr[7:0];
    end
  end

  // force_safe parks every clock at its slow default, e.g. for bring-up
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      force_safe_r <= 1'b0;
    end else if (wr_pend_r && addr_r == `PRCD_REG_CONTROL) begin
      force_safe_r <= hwdata[0];
    end
  end
endmodule

// ### hdl/prcd_consts.svh
// constants for the clock ratio decoder: field codes, safe defaults, register map
`ifndef PRCD_CONSTS_SVH
`define PRCD_CONSTS_SVH
`define PRCD_CFG_W 52
`define PRCD_CL_MULT_MIN 5'h08
`define PRCD_CL_MULT_MAX 5'h12
`define PRCD_CL_SAFE 5'h08
`define PRCD_SEL_P1_D1 4'h0
`define PRCD_SEL_P1_D2 4'h1
`define PRCD_SEL_P2_D1 4'h4
`define PRCD_SEL_P2_D2 4'h5
`define PRCD_MEM_SYNC_RATIO 5'h01
`define PRCD_MEM_ASYNC_SAFE 5'h05
`define PRCD_MEM_R5 5'h05
`define PRCD_MEM_R6 5'h06
`define PRCD_MEM_R8 5'h08
`define PRCD_MEM_R9 5'h09
`define PRCD_MEM_R10 5'h0a
`define PRCD_MEM_R12 5'h0c
`define PRCD_MEM_R13 5'h0d
`define PRCD_MEM_R16 5'h10
`define PRCD_MEM_R18 5'h12
`define PRCD_SD_C20 3'h1
`define PRCD_SD_C25 3'h2
`define PRCD_SD_C40 3'h3
`define PRCD_SD_C50 3'h4
`define PRCD_SD_C24 3'h5
`define PRCD_SD_C30 3'h6
`define PRCD_SD_M20 6'h14
`define PRCD_SD_M24 6'h18
`define PRCD_SD_M25 6'h19
`define PRCD_SD_M30 6'h1e
`define PRCD_SD_M40 6'h28
`define PRCD_SD_M50 6'h32
`define PRCD_SD_SAFE 6'h19
`define PRCD_CORE_SRC_SAFE 4'hc
`define PRCD_CORE_DIV_SAFE 4'hf
`define PRCD_SD_B1_DIV_SAFE 5'h1f
`define PRCD_SD_B2_DIV_SAFE 4'hf
`define PRCD_REG_STATUS 8'h00
`define PRCD_REG_CLUSTER 8'h04
`define PRCD_REG_CORE 8'h08
`define PRCD_REG_MEM 8'h0c
`define PRCD_REG_SERDES 8'h10
`define PRCD_REG_CONTROL 8'h14
`define PRCD_HTRANS_NONSEQ 2'h2
`define PRCD_HTRANS_SEQ 2'h3
`endif

// ### hdl/prcd_pkg.sv
// types shared by the clock ratio decoder files
package prcd_pkg;
  typedef enum logic {PRCD_WAIT, PRCD_LOCKED} prcd_cap_state_t;
  typedef enum logic {PRCD_SRC_PLL_ONE, PRCD_SRC_PLL_TWO} prcd_src_t;
endpackage

// ### hdl/prcd_cfg_capture.sv
// one-shot capture of the power-up configuration word fields
`timescale 1ns/1ps
`include "prcd_consts.svh"
module prcd_cfg_capture
  import prcd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cfg_valid,
  input wire logic [`PRCD_CFG_W-1:0] cfg_in,
  output logic [`PRCD_CFG_W-1:0] cfg_r,
  output logic locked
);
  prcd_cap_state_t state_r;

  // later loads are ignored so ratios cannot move under running plls
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= PRCD_WAIT;
    end else begin
      unique case (state_r)
        PRCD_WAIT: if (cfg_valid) state_r <= PRCD_LOCKED;
        PRCD_LOCKED: state_r <= PRCD_LOCKED;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_r <= '0;
    end else if (state_r == PRCD_WAIT && cfg_valid) begin
      cfg_r <= cfg_in;
    end
  end

  assign locked = (state_r == PRCD_LOCKED);
endmodule

// ### tb/prcd_decoder_properties.sv
// concurrent checks on the clock ratio decoder ports
`timescale 1ns/1ps
`include "prcd_consts.svh"
module prcd_decoder_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cfg_valid,
  input wire logic [4:0] cluster_pll_multiplier_one,
  input wire logic memory_sync_mode,
  input wire logic cfg_locked,
  input wire logic cfg_error,
  input wire logic [4:0] cluster_one_mult_r,
  input wire logic [3:0] core_src_pll_two_r,
  input wire logic [3:0] core_div2_r,
  input wire logic [4:0] mem_mult_r,
  input wire logic mem_ref_platform_r,
  input wire logic [5:0] serdes_bank1_mult_r,
  input wire logic [3:0] serdes_bank2_div2_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // capture edge, then the lock flag one edge later
  sequence s_load;
    cfg_valid && !cfg_locked ##1 cfg_locked;
  endsequence
  a_lock_on_valid: assert property (cfg_valid && !cfg_locked |=> cfg_locked)
    else $error("valid strobe did not lock");
  a_lock_sticky: assert property (cfg_locked |=> cfg_locked)
    else $error("lock dropped without reset");
  a_cluster_legal: assert property (cluster_one_mult_r inside {[`PRCD_CL_MULT_MIN:`PRCD_CL_MULT_MAX]})
    else $error("cluster multiplier out of range");
  a_low_core_sel: assert property (!(core_src_pll_two_r[0] && core_div2_r[0])
    && !(core_src_pll_two_r[1] && core_div2_r[1]))
    else $error("complex 0 or 1 on pll two halved");
  a_high_core_sel: assert property (!(!core_src_pll_two_r[2] && core_div2_r[2])
    && !(!core_src_pll_two_r[3] && core_div2_r[3]))
    else $error("complex 2 or 3 on pll one halved");
  a_async_ratio: assert property (!mem_ref_platform_r |-> mem_mult_r inside {5'h05, 5'h06, 5'h08, 5'h09, 5'h0a,
    5'h0c, 5'h0d, 5'h10, 5'h12})
    else $error("async memory ratio not legal");
  a_sync_ratio: assert property (mem_ref_platform_r |-> mem_mult_r == `PRCD_MEM_SYNC_RATIO)
    else $error("sync memory ratio not one");
  a_mem_ref_mode: assert property (s_load |=> mem_ref_platform_r == $past(memory_sync_mode, 2))
    else $error("memory reference does not follow mode bit");
  a_reserved_flag: assert property (s_load ##0 !(cluster_pll_multiplier_one inside {[5'h08:5'h12]})
    |=> cfg_error)
    else $error("reserved cluster code not flagged");
  a_prelock_safe: assert property (!cfg_locked |-> cluster_one_mult_r == `PRCD_CL_SAFE
    && core_div2_r == 4'hf)
    else $error("outputs not safe before lock");
  a_serdes_b1: assert property (serdes_bank1_mult_r inside {6'h19, 6'h28, 6'h32})
    else $error("bank one multiplier not legal");
  a_bank2_div_all: assert property (serdes_bank2_div2_r inside {4'h0, 4'hf})
    else $error("bank two lanes divided unequally");
endmodule
bind prcd_decoder prcd_decoder_properties u_props (.sys_clk, .rst, .cfg_valid, .cluster_pll_multiplier_one,
  .memory_sync_mode, .cfg_locked, .cfg_error, .cluster_one_mult_r, .core_src_pll_two_r, .core_div2_r,
  .mem_mult_r, .mem_ref_platform_r, .serdes_bank1_mult_r, .serdes_bank2_div2_r);

// ### tb/prcd_loader_model.sv
// loader model: latches a power-up word and strobes it into the decoder
`timescale 1ns/1ps
module prcd_loader_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [51:0] word,
  output logic cfg_valid,
  output logic [51:0] fields
);
  initial begin
    cfg_valid = 1'b0;
    fields = '0;
  end
  // fields keep standing after the strobe, like strapped word bits
  always @(posedge sys_clk) begin
    cfg_valid <= go;
    if (go) begin
      fields <= word;
    end
  end
endmodule

// ### tb/tb_pll_ratio_config_decode.sv
// self-checking bench for the clock ratio decoder
`timescale 1ns/1ps
module tb_pll_ratio_config_decode;
  typedef struct packed {
    logic [4:0] cl1, cl2;
    logic [1:0] r1, r2;
    logic [15:0] sel;
    logic [4:0] mem;
    logic [1:0] mr;
    logic sync, rate, rsv;
    logic [2:0] b1, b2;
    logic [4:0] d1;
    logic d2;
  } prcd_tbw_t;
  // cluster one 18x of 66 MHz sits above 1 GHz, memory 18x above its cutoff
  localparam prcd_tbw_t base_w = '{5'h12, 5'h08, 2'h0, 2'h1, 16'h1450, 5'h12, 2'h1, 1'b0, 1'b0, 1'b0, 3'h4,
    3'h1, 5'h15, 1'b1};
  logic sys_clk, rst, go, hsel, hwrite, cfg_valid, hreadyout, hresp, cfg_locked, cfg_error;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [4:0] cl1_m, mem_m;
  logic [5:0] sd1_m, sd2_m;
  prcd_tbw_t w, f;
  int n_mismatch, n_tests;
  prcd_loader_model u_ld (.sys_clk, .go, .word(w), .cfg_valid, .fields(f));
  prcd_decoder DUT (.sys_clk, .rst, .cfg_valid, .cluster_pll_multiplier_one(f.cl1),
    .cluster_pll_multiplier_two(f.cl2), .cluster_pll_range_one(f.r1), .cluster_pll_range_two(f.r2),
    .core_complex_clock_select(f.sel),
    .memory_pll_multiplier(f.mem), .memory_pll_range(f.mr), .memory_sync_mode(f.sync), .memory_rate_bit(f.rate),
    .memory_reserved_bit(f.rsv), .serdes_bank1_multiplier(f.b1), .serdes_bank2_multiplier(f.b2),
    .serdes_bank1_lane_divider(f.d1), .serdes_bank2_lane_divider(f.d2), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cfg_locked, .cfg_error,
    .cluster_one_mult_r(cl1_m), .cluster_two_mult_r(), .cluster_one_range_r(), .cluster_two_range_r(),
    .core_src_pll_two_r(), .core_div2_r(), .mem_mult_r(mem_m), .mem_range_r(), .mem_ref_platform_r(),
    .serdes_bank1_mult_r(sd1_m), .serdes_bank2_mult_r(sd2_m), .serdes_bank1_div2_r(), .serdes_bank2_div2_r());
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_up;
    n_mismatch++;
    $display("Error at %0t: wait ran out", $time);
    close_out;
  endtask
  // bounded wait for hready at a rising edge
  task automatic edge_rdy;
    int k;
    k = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 16) give_up;
      @(posedge sys_clk);
    end
  endtask
  // single word transfer; on a read, d is the expected data
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    edge_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy;
    if (!wr) chk(hrdata, d);
    chk(hresp, 1'b0);
  endtask
  // only one load per reset, so every word gets a fresh reset
  task automatic load(input prcd_tbw_t v);
    int k;
    rst <= 1'b1;
    w <= v;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    for (k = 0; cfg_locked !== 1'b1; k++) begin
      if (k > 8) give_up;
      @(posedge sys_clk);
    end
    repeat (2) @(posedge sys_clk);
  endtask
  function automatic logic [5:0] sd(input logic [2:0] c, input logic b2);
    case (c)
      3'h1: return b2 ? 6'h14 : 6'h19;
      3'h3: return 6'h28;
      3'h4: return 6'h32;
      3'h5: return b2 ? 6'h18 : 6'h19;
      3'h6: return b2 ? 6'h1e : 6'h19;
      default: return 6'h19;
    endcase
  endfunction
  initial begin
    prcd_tbw_t v;
    logic ok, mok;
    rst = 1'b1;
    go = 1'b0;
    w = base_w;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    ahb(1'b0, 32'h0, 32'h0);
    ahb(1'b0, 32'h4, 32'h808);
    ahb(1'b0, 32'h8, 32'hfc);
    ahb(1'b0, 32'h10, 32'h01ff1919);
    $display("reset defaults done");
    load(base_w);
    ahb(1'b0, 32'h0, 32'h1);
    ahb(1'b0, 32'h4, 32'h40812);
    ahb(1'b0, 32'h8, 32'h56);
    ahb(1'b0, 32'hc, 32'h32);
    ahb(1'b0, 32'h10, 32'h01f51432);
    v = base_w;
    v.cl1 = 5'h09;
    w <= v;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (3) @(posedge sys_clk);
    ahb(1'b0, 32'h4, 32'h40812);
    $display("legal load done");
    ahb(1'b1, 32'h14, 32'h1);
    ahb(1'b0, 32'h14, 32'h1);
    ahb(1'b0, 32'h4, 32'h808);
    ahb(1'b1, 32'h14, 32'h0);
    ahb(1'b1, 32'h0, 32'hffffffff);
    ahb(1'b1, 32'h40, 32'hffffffff);
    ahb(1'b0, 32'h0, 32'h1);
    ahb(1'b0, 32'h40, 32'h0);
    ahb(1'b0, 32'h4, 32'h40812);
    $display("register access done");
    v = base_w;
    v.cl1 = 5'h13;
    v.sel = 16'h5001;
    v.sync = 1'b1;
    v.mem = 5'h05;
    v.mr = 2'h0;
    v.rsv = 1'b1;
    v.rate = 1'b1;
    v.b1 = 3'h1;
    v.b2 = 3'h0;
    load(v);
    ahb(1'b0, 32'h0, 32'h1bcb);
    ahb(1'b0, 32'h8, 32'h98);
    ahb(1'b0, 32'hc, 32'h81);
    ahb(1'b0, 32'h4, 32'h40808);
    v = base_w;
    v.rate = 1'b1;
    load(v);
    ahb(1'b0, 32'h0, 32'h1401);
    $display("reserved codes done");
    for (int i = 0; i < 32; i++) begin
      v = base_w;
      v.cl1 = i[4:0];
      v.mem = i[4:0];
      v.b1 = i[2:0];
      v.b2 = i[2:0];
      load(v);
      ok = i inside {[8:18]};
      mok = i inside {5, 6, 8, 9, 10, 12, 13, 16, 18};
      chk(cl1_m, ok ? i : 8);
      chk(mem_m, mok ? i : 5);
      chk(sd1_m, sd(i[2:0], 1'b0));
      chk(sd2_m, sd(i[2:0], 1'b1));
      chk(cfg_error, !ok || !mok || !(i[2:0] inside {2, 3, 4}));
    end
    $display("code sweep done");
    close_out;
  end
endmodule
